// [rtl/wbc_pkg.sv]
`default_nettype none
package wbc_pkg;
	localparam int          CHIPS     = 8;
	localparam int          MAG_W     = 3;
	localparam int          NIB_W     = 4;
	localparam int          SYM_BITS  = 8;
	localparam logic [3:0]  CNT_FULL  = 4'h8;
	localparam logic [2:0]  CHIP_LAST = 3'h7;
	localparam logic [2:0]  CHIP_ZERO = 3'h0;
	// Same pattern flipped into every row: distances between rows are kept,
	// and since no row has weight one the result has no all-zero member.
	localparam logic [7:0]  CODE_MASK = 8'h01;
	localparam logic [7:0]  CODE_ZERO = 8'h00;

	typedef struct packed {
		logic             pol;
		logic [MAG_W-1:0] mag;
	} wbc_sym_t;

	typedef struct packed {
		logic i;
		logic q;
	} wbc_chip_t;

	// Row idx of the order-3 matrix: each doubling copies the previous
	// matrix into three quadrants and its complement into the lower right.
	function automatic logic [7:0] wbc_code(input logic [MAG_W-1:0] idx);
		logic [7:0] row;
		row = CODE_ZERO;
		for (int c = 0; c < CHIPS; c++) begin
			for (int k = 0; k < MAG_W; k++) begin
				if (idx[k] && c[k]) begin
					row[c] = ~row[c];
				end
			end
		end
		return row ^ CODE_MASK;
	endfunction

	function automatic logic wbc_chip(input wbc_sym_t s, input logic [2:0] idx);
		logic [7:0] w;
		w = wbc_code(s.mag);
		return w[idx] ^ s.pol;
	endfunction

	// r[0] is the first bit on the wire within the group
	function automatic wbc_sym_t wbc_to_sym(input logic [3:0] r, input logic msb_first);
		logic [3:0] n;
		n = msb_first ? {r[0], r[1], r[2], r[3]} : r;
		return wbc_sym_t'(n);
	endfunction

	function automatic logic [3:0] wbc_from_sym(input wbc_sym_t s, input logic msb_first);
		logic [3:0] n;
		n = s;
		return msb_first ? {n[0], n[1], n[2], n[3]} : n;
	endfunction
endpackage
`default_nettype wire

// [rtl/wbc_corr.sv]
`timescale 1ns/1ns
`default_nettype none
module wbc_corr import wbc_pkg::*; #(
	parameter int RX_W = 8
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   chip_valid,
	input  wire logic                   chip_last,
	input  wire logic [2:0]             chip_idx,
	input  wire logic signed [RX_W-1:0] chip,
	output var  logic                   dec_valid_q,
	output var  wbc_sym_t               dec_sym_q
);
	localparam int ACC_W = RX_W + 4;

	if (RX_W < 2) begin
		$error("RX_W must be at least 2");
	end

	logic signed [ACC_W-1:0] acc_q   [CHIPS];
	logic signed [ACC_W-1:0] total   [CHIPS];
	logic signed [ACC_W-1:0] chip_x;
	logic [MAG_W-1:0]        best;
	logic [ACC_W-1:0]        best_abs;
	logic [ACC_W-1:0]        cand_abs;
	wire                     dump = chip_valid && chip_last;

	// Chip c of code row m
	function automatic logic code_bit(input logic [MAG_W-1:0] m, input logic [2:0] c);
		logic [7:0] w;
		w = wbc_code(m);
		return w[c];
	endfunction

	function automatic logic [ACC_W-1:0] abs_of(input logic signed [ACC_W-1:0] v);
		return v[ACC_W-1] ? ACC_W'(-v) : ACC_W'(v);
	endfunction

	assign chip_x = ACC_W'(chip);

	// One multiply-accumulate per code word; code chip 1 means -1
	always_comb begin
		for (int k = 0; k < CHIPS; k++) begin
			total[k] = code_bit(MAG_W'(k), chip_idx) ? acc_q[k] - chip_x
			                                         : acc_q[k] + chip_x;
		end
	end

	// Largest magnitude wins; its sign carries the polarity
	always_comb begin
		best     = '0;
		best_abs = abs_of(total[0]);
		cand_abs = '0;
		for (int k = 1; k < CHIPS; k++) begin
			cand_abs = abs_of(total[k]);
			if (cand_abs > best_abs) begin
				best     = MAG_W'(k);
				best_abs = cand_abs;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int k = 0; k < CHIPS; k++) begin
				acc_q[k] <= '0;
			end
		end else if (chip_valid) begin
			for (int k = 0; k < CHIPS; k++) begin
				acc_q[k] <= dump ? '0 : total[k];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dec_valid_q <= 1'b0;
			dec_sym_q   <= '0;
		end else begin
			dec_valid_q <= dump;
			if (dump) begin
				dec_sym_q.mag <= best;
				dec_sym_q.pol <= total[best][ACC_W-1];
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_dump_clears:   assert property (dump |=> acc_q[3] == '0 && dec_valid_q)
		else $error("accumulator not dumped at symbol end");
	chk_mac_step:      assert property (chip_valid && !chip_last |=>
		acc_q[0] == $past(acc_q[0]) + (code_bit(3'h0, $past(chip_idx)) ? -$past(chip_x)
		: $past(chip_x)))
		else $error("accumulator zero did not add its product");
	chk_idle_hold:     assert property (!chip_valid |=> $stable(acc_q[5]))
		else $error("accumulator moved without a chip");
	cov_inverted:      cover property (dec_valid_q && dec_sym_q.pol);
endmodule
`default_nettype wire

// [rtl/wbc_codec.sv]
`timescale 1ns/1ns
`default_nettype none
module wbc_codec import wbc_pkg::*; #(
	parameter int RX_W      = 8,
	parameter bit MSB_FIRST = 1'b1,
	parameter bit I_FIRST   = 1'b1
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   bit_valid,
	output var  logic                   bit_ready,
	input  wire logic                   bit_data,
	output var  logic                   tx_valid_q,
	output var  wbc_chip_t              tx_chip_q,
	input  wire logic                   rx_valid,
	input  wire logic signed [RX_W-1:0] rx_i,
	input  wire logic signed [RX_W-1:0] rx_q,
	output var  logic                   rx_bits_valid_q,
	output var  logic [SYM_BITS-1:0]    rx_bits_q
);
	typedef enum logic {TX_IDLE, TX_SEND} wbc_tx_state_t;

	// Soft chips need a sign bit and at least one bit of size
	if (RX_W < 2) begin
		$error("RX_W must be at least 2 for signed soft chips");
	end

	wbc_tx_state_t          state_q, state_d;
	logic [SYM_BITS-1:0]    asm_q;
	logic [3:0]             cnt_q;
	logic [2:0]             tx_idx_q, tx_idx_d;
	wbc_sym_t               sym_i_q, sym_q_q, sym_i_d, sym_q_d;
	logic [2:0]             rx_idx_q;
	wbc_sym_t               dec_i, dec_q;
	logic                   dec_i_valid, dec_q_valid;

	wire full      = cnt_q == CNT_FULL;
	wire last_chip = state_q == TX_SEND && tx_idx_q == CHIP_LAST;
	// A waiting symbol loads at once when idle, else only on the last chip, so a word is never cut short
	wire load      = full && (state_q == TX_IDLE || last_chip);
	wire take_bit  = bit_valid && bit_ready;
	wire rx_last   = rx_idx_q == CHIP_LAST;
	wire [3:0] grp_first  = asm_q[3:0];
	wire [3:0] grp_second = asm_q[7:4];
	wire wbc_sym_t new_first  = wbc_to_sym(grp_first, MSB_FIRST);
	wire wbc_sym_t new_second = wbc_to_sym(grp_second, MSB_FIRST);

	assign bit_ready = !full;

	// Gather one symbol's worth of bits; bit k of asm_q is the k-th bit received
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			asm_q <= '0;
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= '0;
		end else if (take_bit) begin
			asm_q[cnt_q[2:0]] <= bit_data;
			cnt_q             <= cnt_q + 4'h1;
		end
	end

	// Two groups per symbol, split to channels by I_FIRST
	assign sym_i_d = load ? (I_FIRST ? new_first : new_second) : sym_i_q;
	assign sym_q_d = load ? (I_FIRST ? new_second : new_first) : sym_q_q;

	always_comb begin
		state_d  = state_q;
		tx_idx_d = tx_idx_q;
		case (state_q)
			TX_IDLE: begin
				if (load) begin
					state_d  = TX_SEND;
					tx_idx_d = CHIP_ZERO;
				end
			end
			TX_SEND: begin
				tx_idx_d = tx_idx_q + 3'h1;
				if (last_chip && !load) begin
					state_d = TX_IDLE;
				end
			end
			default: begin
				state_d = TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q  <= TX_IDLE;
			tx_idx_q <= '0;
			sym_i_q  <= '0;
			sym_q_q  <= '0;
		end else begin
			state_q  <= state_d;
			tx_idx_q <= tx_idx_d;
			sym_i_q  <= sym_i_d;
			sym_q_q  <= sym_q_d;
		end
	end

	// Chip outputs registered; code row selected by magnitude, then polarity flip
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_valid_q <= 1'b0;
			tx_chip_q  <= '0;
		end else begin
			tx_valid_q  <= state_d == TX_SEND;
			tx_chip_q.i <= wbc_chip(sym_i_d, tx_idx_d);
			tx_chip_q.q <= wbc_chip(sym_q_d, tx_idx_d);
		end
	end

	// Receive chip position; a symbol closes every eighth valid chip
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_idx_q <= '0;
		end else if (rx_valid) begin
			rx_idx_q <= rx_idx_q + 3'h1;
		end
	end

	wbc_corr #(.RX_W(RX_W)) u_corr_i (
		.clk        (clk),
		.resetn     (resetn),
		.chip_valid (rx_valid),
		.chip_last  (rx_last),
		.chip_idx   (rx_idx_q),
		.chip       (rx_i),
		.dec_valid_q(dec_i_valid),
		.dec_sym_q  (dec_i)
	);

	wbc_corr #(.RX_W(RX_W)) u_corr_q (
		.clk        (clk),
		.resetn     (resetn),
		.chip_valid (rx_valid),
		.chip_last  (rx_last),
		.chip_idx   (rx_idx_q),
		.chip       (rx_q),
		.dec_valid_q(dec_q_valid),
		.dec_sym_q  (dec_q)
	);

	wire [3:0] out_i = wbc_from_sym(dec_i, MSB_FIRST);
	wire [3:0] out_q = wbc_from_sym(dec_q, MSB_FIRST);
	// Both halves close on the same chip, so the in-phase strobe stands for both

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_bits_valid_q <= 1'b0;
			rx_bits_q       <= '0;
		end else begin
			rx_bits_valid_q <= dec_i_valid;
			if (dec_i_valid) begin
				rx_bits_q <= I_FIRST ? {out_q, out_i} : {out_i, out_q};
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_ready_full:    assert property (full |-> !bit_ready)
		else $error("bit accepted while a symbol is waiting");
	chk_symbol_len:    assert property (load |=> tx_valid_q [*8])
		else $error("symbol shorter than eight chips");
	// Row checks use the parity form, not the lookup, so a table slip shows
	chk_first_chip:    assert property (load ##1 1 |-> tx_chip_q.i ==
		(CODE_MASK[CHIP_ZERO] ^ $past(sym_i_d.pol)))
		else $error("first in-phase chip does not match selected word");
	chk_pol_from_bits: assert property (load && I_FIRST |=> sym_i_q ==
		wbc_to_sym($past(asm_q[3:0]), MSB_FIRST))
		else $error("in-phase symbol not taken from first group");
	chk_no_zero_word:  assert property (wbc_code(sym_i_q.mag) != CODE_ZERO)
		else $error("all-zero code word selected");
	chk_half_agree:    assert property (sym_i_q.mag != sym_q_q.mag |->
		$countones(wbc_code(sym_i_q.mag) ^ wbc_code(sym_q_q.mag)) == 4)
		else $error("two code words not orthogonal");
	chk_rx_decision:   assert property (rx_valid && rx_last |-> ##2 rx_bits_valid_q)
		else $error("no decision two cycles after symbol end");
	chk_rx_quiet:      assert property (!(rx_valid && rx_last) |-> ##2 !rx_bits_valid_q)
		else $error("decision without a symbol end");
	chk_load_reopens:  assert property (load |=> bit_ready && cnt_q == '0)
		else $error("input not reopened after a symbol load");
	chk_cnt_bound:     assert property (cnt_q <= CNT_FULL)
		else $error("bit count beyond one symbol");
	chk_q_from_group:  assert property (load && I_FIRST |=> sym_q_q ==
		wbc_to_sym($past(asm_q[7:4]), MSB_FIRST))
		else $error("quadrature symbol not taken from second group");
	chk_i_chip_row:    assert property (tx_valid_q |-> tx_chip_q.i ==
		((^(sym_i_q.mag & tx_idx_q)) ^ CODE_MASK[tx_idx_q] ^ sym_i_q.pol))
		else $error("in-phase chip differs from its code row");
	chk_q_chip_row:    assert property (tx_valid_q |-> tx_chip_q.q ==
		((^(sym_q_q.mag & tx_idx_q)) ^ CODE_MASK[tx_idx_q] ^ sym_q_q.pol))
		else $error("quadrature chip differs from its code row");
	chk_idx_start:     assert property (load |=> tx_idx_q == CHIP_ZERO)
		else $error("symbol did not start at chip zero");
	chk_tx_quiet:      assert property (state_q == TX_IDLE && !load |=> !tx_valid_q)
		else $error("chip sent with no symbol loaded");
	chk_rx_bits_hold:  assert property (!dec_i_valid |=> $stable(rx_bits_q))
		else $error("decoded bits changed without a decision");
	chk_rx_pair:       assert property (dec_i_valid == dec_q_valid)
		else $error("in-phase and quadrature decisions out of step");

	cov_back_to_back:  cover property (last_chip && load);
	cov_tx_inverted:   cover property (load ##1 sym_q_q.pol);
	cov_rx_symbol:     cover property (rx_bits_valid_q);
	cov_refused:       cover property (bit_valid && !bit_ready);
endmodule
`default_nettype wire

// [test/wbc_radio_model.sv]
`timescale 1ns/1ns
`default_nettype none
module wbc_radio_model import wbc_pkg::*; #(
	parameter int RX_W = 8
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   tx_valid_q,
	input  wire wbc_chip_t              tx_chip_q,
	input  wire logic                   flip_en,
	input  wire logic [2:0]             flip_idx,
	input  wire logic signed [RX_W-1:0] amp,
	output var  logic                   rx_valid,
	output var  logic signed [RX_W-1:0] rx_i,
	output var  logic signed [RX_W-1:0] rx_q
);
	logic [2:0]             cnt_q;
	logic [RX_W-1:0]        junk_q;
	logic                   hit;
	logic signed [RX_W-1:0] soft_i;
	logic signed [RX_W-1:0] soft_q;

	// One chip in error on the in-phase path when asked for
	assign hit    = flip_en && (cnt_q == flip_idx);
	assign soft_i = (tx_chip_q.i ^ hit) ? -amp : amp;
	assign soft_q = tx_chip_q.q ? -amp : amp;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q    <= 3'h0;
			junk_q   <= '0;
			rx_valid <= 1'b0;
			rx_i     <= '0;
			rx_q     <= '0;
		end else begin
			junk_q   <= junk_q + RX_W'(8'h35);
			rx_valid <= tx_valid_q;
			if (tx_valid_q) begin
				cnt_q <= cnt_q + 3'h1;
				rx_i  <= soft_i;
				rx_q  <= soft_q;
			end else begin
				// Line carries nothing: changing junk, never the last chip
				rx_i <= junk_q;
				rx_q <= ~junk_q;
			end
		end
	end
endmodule
`default_nettype wire

// [test/walsh_biorthogonal_codec_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module walsh_biorthogonal_codec_tb;
	import wbc_pkg::*;
	logic                clk = 1'b0;
	logic                resetn = 1'b0;
	logic                bit_valid = 1'b0;
	logic                bit_data = 1'b0;
	logic                bit_ready;
	logic                tx_valid_q;
	wbc_chip_t           tx_chip_q;
	logic                rx_valid;
	logic signed [7:0]   rx_i;
	logic signed [7:0]   rx_q;
	logic                rx_bits_valid_q;
	logic [7:0]          rx_bits_q;
	logic                flip_en = 1'b0;
	logic [2:0]          flip_idx = 3'h5;
	logic signed [7:0]   amp = 8'sh3C;
	int                  miscompares = 0;
	int                  checks = 0;
	int                  cyc = 0;
	int                  refused = 0;
	wbc_chip_t           txq[$];
	logic [7:0]          rxq[$];

	wbc_codec #(.RX_W(8)) DUT (.clk(clk), .resetn(resetn), .bit_valid(bit_valid),
		.bit_ready(bit_ready), .bit_data(bit_data), .tx_valid_q(tx_valid_q),
		.tx_chip_q(tx_chip_q), .rx_valid(rx_valid), .rx_i(rx_i), .rx_q(rx_q),
		.rx_bits_valid_q(rx_bits_valid_q), .rx_bits_q(rx_bits_q));
	wbc_radio_model #(.RX_W(8)) radio (.clk(clk), .resetn(resetn), .tx_valid_q(tx_valid_q),
		.tx_chip_q(tx_chip_q), .flip_en(flip_en), .flip_idx(flip_idx), .amp(amp),
		.rx_valid(rx_valid), .rx_i(rx_i), .rx_q(rx_q));

	initial begin
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (tx_valid_q === 1'b1) txq.push_back(tx_chip_q);
		if (rx_bits_valid_q === 1'b1) rxq.push_back(rx_bits_q);
		if (cyc == 5000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check_bit(input logic got, input logic exp, input string msg);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	function automatic logic exp_chip(input logic [3:0] nib, input int c);
		logic [2:0] ci;
		ci = c[2:0];
		return (^(nib[2:0] & ci)) ^ CODE_MASK[ci] ^ nib[3];
	endfunction

	// Wire order: in-phase group first, polarity then magnitude MSB first
	function automatic logic [7:0] mk_byte(input logic [3:0] ni, input logic [3:0] nq);
		return {nq[0], nq[1], nq[2], nq[3], ni[0], ni[1], ni[2], ni[3]};
	endfunction

	task automatic send_bit(input logic b);
		logic r;
		r = 1'b0;
		while (!r) begin
			bit_valid = 1'b1;
			bit_data  = b;
			#2 r = bit_ready;
			if (!r) refused++;
			@(posedge clk);
			#1;
		end
	endtask

	task automatic sc_stream(input int n, input logic fl, input logic signed [7:0] a);
		logic [7:0] e;
		logic [7:0] wi[16];
		logic [3:0] ni;
		int         w;
		txq.delete();
		rxq.delete();
		flip_en = fl;
		amp     = a;
		refused = 0;
		for (int s = 0; s < n; s++) begin
			e = mk_byte(s[3:0], ~s[3:0]);
			for (int k = 0; k < 8; k++) send_bit(e[k]);
		end
		bit_valid = 1'b0;
		w = 0;
		while (rxq.size() < n && w < 300) begin
			@(posedge clk);
			w++;
		end
		#1;
		check_bit(txq.size() == 8 * n, 1'b1, "chip count");
		check_bit(refused > 0, 1'b1, "no hold-off after eight bits");
		for (int s = 0; s < n && txq.size() == 8 * n; s++) begin
			ni = s[3:0];
			for (int c = 0; c < 8; c++) begin
				wi[s][c] = txq[s * 8 + c].i;
				check_bit(txq[s * 8 + c].i, exp_chip(ni, c), "I chip");
				check_bit(txq[s * 8 + c].q, exp_chip(~ni, c), "Q chip");
			end
			check_bit(wi[s] != 8'h00, 1'b1, "all-zero word");
		end
		for (int s = 0; s < n && rxq.size() == n; s++) begin
			check_byte(rxq[s], mk_byte(s[3:0], ~s[3:0]), "decoded bits");
		end
		check_bit(rxq.size() == n, 1'b1, "decoded symbol count");
		if (n >= 8 && txq.size() == 8 * n) begin
			for (int p = 0; p < 8; p++) begin
				for (int q = p + 1; q < 8; q++) begin
					check_byte(8'($countones(~(wi[p] ^ wi[q]))), 8'h04, "agreement");
				end
			end
		end
	endtask

	// Reset in mid-symbol: everything drops at once and framing starts over
	task automatic sc_reset_mid();
		for (int k = 0; k < 8; k++) begin
			send_bit(k[0]);
		end
		bit_valid = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check_bit(tx_valid_q, 1'b1, "symbol under way");
		resetn = 1'b0;
		@(posedge clk);
		#1;
		check_bit(tx_valid_q, 1'b0, "tx dropped by reset");
		check_bit(bit_ready, 1'b1, "ready after reset");
		check_bit(rx_bits_valid_q, 1'b0, "rx idle after reset");
		@(posedge clk);
		#1;
		resetn = 1'b1;
		sc_stream(8, 1'b0, 8'sh3C);
	endtask

	initial begin
		repeat (11) @(posedge clk);
		#1;
		check_bit(bit_ready, 1'b1, "ready in reset");
		check_bit(tx_valid_q, 1'b0, "tx idle in reset");
		check_bit(rx_bits_valid_q, 1'b0, "rx idle in reset");
		check_byte(rx_bits_q, 8'h00, "rx bits in reset");
		@(posedge clk);
		#1;
		resetn = 1'b1;
		// Every nibble on both paths, strong clean channel
		sc_stream(16, 1'b0, 8'sh3C);
		// Weak channel, one chip wrong per symbol, after an idle gap
		repeat (5) @(posedge clk);
		#1;
		sc_stream(8, 1'b1, 8'sh03);
		// Reset mid-run, then a clean stream must decode from chip zero again
		sc_reset_mid();
		finish_test();
	end
endmodule
`default_nettype wire
